// ---- rtl/flic_pkg.sv ----
package flic_pkg;
  // ------------------------------------------------------------
  // register map (printed offsets are not all multiples of 4: index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_ENABLE_PRIMARY = 8'hA8; // interrupt_enable_primary
  localparam logic [7:0] IDX_ENABLE_TIMER = 8'hE8; // interrupt_enable_timer_events
  localparam logic [7:0] IDX_PRIO_LOW_A = 8'hB8; // priority_low_bits, first group
  localparam logic [7:0] IDX_PRIO_HIGH_A = 8'hB7; // priority_high_bits, first group
  localparam logic [7:0] IDX_PRIO_LOW_B = 8'hF8; // priority_low_bits, timer group
  localparam logic [7:0] IDX_PRIO_HIGH_B = 8'hF7; // priority_high_bits, timer group
  localparam logic [7:0] IDX_FLAGS_A = 8'hC0; // pending flags, first group
  localparam logic [7:0] IDX_FLAGS_B = 8'hC1; // pending flags, timer group
  localparam logic [7:0] IDX_SERVICE = 8'hC2; // in-service levels, read only
  localparam logic [7:0] IDX_VECTOR = 8'hC3; // current vector, read only
  localparam logic [7:0] IDX_RETURN = 8'hC4; // write ends the top service
  localparam int ADDR_LSB = 2;
  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int NSRC = 15;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // flag bit in first group: 0 ext0,1 t0,2 ext1,3 t1,4 uart rx,5 uart tx,6 i2c,7 adc
  localparam int FA_UART_RX = 4;
  localparam int FA_UART_TX = 5;
  localparam int FA_I2C = 6;
  localparam int FA_ADC = 7;
  // flag bit in timer group: 0..3 capture, 4..6 compare, 7 byte overflow; full overflow separate
  // source index (vector order): 0 x0,1 t0,2 x1,3 t1,4 uart,5 i2c,6..9 cap,10 adc,11..13 cmp,14 ovf
  localparam int S_UART = 4;
  localparam int S_I2C = 5;
  localparam int S_CAP0 = 6;
  localparam int S_ADC = 10;
  localparam int S_CMP0 = 11;
  localparam int S_OVF = 14;
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam int VEC_SHIFT = 3;
  // fixed order of selection within a level, first wins
  localparam logic [59:0] SEL_ORDER = {4'd14, 4'd9, 4'd4, 4'd13, 4'd8, 4'd3, 4'd12, 4'd7,
                                       4'd2, 4'd11, 4'd6, 4'd1, 4'd10, 4'd5, 4'd0};
endpackage

// ---- rtl/flic_top.sv ----
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// [R1] fifteen sources, four levels each, independent
// [R2] uart request is rx or tx done
// [R3] timer gives eight requests, overflows ORed
// [R4] compare on count match, capture on input
// [R5] low byte and full overflow set flags
// [R6] timer flags cleared only by software
// [R7] conversion flag set on result, software clears
// [R8] i2c flag set on valid status load
// [R9] software may clear, not set, conversion flag
// [R10] other flags software set or clear
// [R11] per-source enable bit gates each request
// [R12] bit 7 global enable gates everything
// [R13] level from high and low priority bits
// [R14] forward only above current service level
// [R15] lower or equal requests wait pending
// [R16] higher pre-empts, nested levels tracked
// [R17] timer enable register bit layout
// [R18] primary enable register bit layout
// [R19] enable one enables, zero disables
// [R20] fixed order among equal levels
// [R21] vectors eight bytes apart from 0003H
module flic_top #(
  parameter int ADDR_W = 10,
  parameter int TIMER_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // classic wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // event sources, one-cycle or level, sampled each edge
  input wire logic EXT_REQUEST_PIN_A,
  input wire logic EXT_REQUEST_PIN_B,
  input wire logic TIMER0_OVF,
  input wire logic TIMER1_OVF,
  input wire logic UART_RX_DONE,
  input wire logic UART_TX_DONE,
  input wire logic I2C_STATUS_LOAD,
  input wire logic ADC_RESULT_READY,
  input wire logic [3:0] CAPTURE_INPUT_SIGNAL,
  input wire logic [TIMER_W-1:0] CC_TIMER_COUNT,
  input wire logic [3*TIMER_W-1:0] CC_COMPARE_VALUES,
  input wire logic CC_TIMER_TICK,
  // cpu core side
  input wire logic CPU_ACCEPT,
  input wire logic CPU_RETURN,
  output logic CPU_IRQ,
  output logic [7:0] CPU_VECTOR
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] en_a; // primary enables
    logic [7:0] en_b; // timer event enables
    logic [7:0] pl_a; // priority low, first group
    logic [7:0] ph_a; // priority high, first group
    logic [7:0] pl_b; // priority low, timer group
    logic [7:0] ph_b; // priority high, timer group
    logic [7:0] fl_a; // flags first group
    logic [7:0] fl_b; // flags timer group
    logic fovf; // full overflow flag
    logic [3:0] ins; // in-service level stack, one bit per level
    logic [7:0] vec; // registered vector
    logic [31:0] rdat; // read data
    logic ack; // bus acknowledge
  } flic_state_t;

  flic_state_t s_q, s_d;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // level of a source from its two priority bits
  function automatic logic [1:0] lvl_of(input logic [7:0] pha, input logic [7:0] pla,
                                        input logic [7:0] phb, input logic [7:0] plb,
                                        input int src);
    logic [1:0] r;
    r = 2'h0;
    // first group holds sources below the captures and the adc
    if ((src < flic_pkg::S_CAP0) || (src == flic_pkg::S_ADC)) begin
      r = {pha[src_bit(src)], pla[src_bit(src)]};
    end else if (src == flic_pkg::S_OVF) begin
      r = {phb[7], plb[7]};
    end else begin
      r = {phb[tbit(src)], plb[tbit(src)]};
    end
    return r;
  endfunction

  // priority/enable bit in first group for sources 0..5 and adc
  function automatic int src_bit(input int src);
    return (src == flic_pkg::S_ADC) ? 6 : src;
  endfunction

  // bit in timer group for capture and compare sources
  function automatic int tbit(input int src);
    return (src >= flic_pkg::S_CMP0) ? (src - flic_pkg::S_CMP0 + 4) : (src - flic_pkg::S_CAP0);
  endfunction

  // byte write helper honouring byte lane 0
  function automatic logic wr_hit(input logic [7:0] idx, input logic [ADDR_W-1:0] adr,
                                  input logic we, input logic [3:0] sel);
    return we && sel[0] && (adr[ADDR_W-1:flic_pkg::ADDR_LSB] == idx);
  endfunction

  // ------------------------------------------------------------
  // request and enable vectors
  // ------------------------------------------------------------
  logic [14:0] req; // raw requests per source index
  logic [14:0] en; // per-source enables
  logic [1:0] lvl [15]; // level per source
  logic [14:0] cmp_hit;
  logic bus_req;

  always_comb begin
    req = '0;
    req[0] = s_q.fl_a[0];
    req[1] = s_q.fl_a[1];
    req[2] = s_q.fl_a[2];
    req[3] = s_q.fl_a[3];
    req[flic_pkg::S_UART] = s_q.fl_a[flic_pkg::FA_UART_RX] | s_q.fl_a[flic_pkg::FA_UART_TX]; // R2
    req[flic_pkg::S_I2C] = s_q.fl_a[flic_pkg::FA_I2C]; // R8
    req[flic_pkg::S_ADC] = s_q.fl_a[flic_pkg::FA_ADC]; // R7
    for (int i = 0; i < 4; i++) begin
      req[flic_pkg::S_CAP0+i] = s_q.fl_b[i]; // R3
    end
    for (int i = 0; i < 3; i++) begin
      req[flic_pkg::S_CMP0+i] = s_q.fl_b[4+i]; // R3
    end
    req[flic_pkg::S_OVF] = s_q.fl_b[7] | s_q.fovf; // R3
    // enable per source, primary bits 0..6, timer bits 0..7
    en = '0;
    for (int i = 0; i < 6; i++) begin
      en[i] = s_q.en_a[i]; // R18 R19
    end
    en[flic_pkg::S_ADC] = s_q.en_a[6]; // R18
    for (int i = 0; i < 4; i++) begin
      en[flic_pkg::S_CAP0+i] = s_q.en_b[i]; // R17
    end
    for (int i = 0; i < 3; i++) begin
      en[flic_pkg::S_CMP0+i] = s_q.en_b[4+i]; // R17
    end
    en[flic_pkg::S_OVF] = s_q.en_b[7]; // R17
    for (int i = 0; i < flic_pkg::NSRC; i++) begin
      lvl[i] = lvl_of(s_q.ph_a, s_q.pl_a, s_q.ph_b, s_q.pl_b, i); // R1 R13
    end
  end

  // ------------------------------------------------------------
  // arbitration: highest level, then fixed order
  // ------------------------------------------------------------
  logic win_v;
  logic [3:0] win_src;
  logic [1:0] win_lvl;
  logic [3:0] cur_src;
  logic [1:0] svc_top; // highest level in service
  logic svc_any;
  logic fwd;

  always_comb begin
    win_v = 1'b0;
    win_src = 4'h0;
    win_lvl = 2'h0;
    cur_src = 4'h0;
    // scan levels high to low, order first to last
    for (int l = 3; l >= 0; l--) begin
      for (int k = 0; k < flic_pkg::NSRC; k++) begin
        cur_src = flic_pkg::SEL_ORDER[4*k +: 4];
        if (!win_v && req[cur_src] && en[cur_src] && (lvl[cur_src] == 2'(l))) begin // R11 R20
          win_v = 1'b1;
          win_src = cur_src;
          win_lvl = 2'(l);
        end
      end
    end
    svc_any = |s_q.ins;
    svc_top = s_q.ins[3] ? 2'd3 : s_q.ins[2] ? 2'd2 : s_q.ins[1] ? 2'd1 : 2'd0;
    // only strictly higher than the level in service gets through
    fwd = s_q.en_a[flic_pkg::GLOBAL_EN_BIT] && win_v && (!svc_any || (win_lvl > svc_top)); // R12 R14 R15 R16
  end

  assign CPU_IRQ = fwd;
  assign CPU_VECTOR = s_q.vec;
  assign WB_DAT_O = s_q.rdat;
  assign WB_ACK_O = s_q.ack;
  assign bus_req = WB_CYC_I && WB_STB_I && !s_q.ack;

  // compare match per channel
  always_comb begin
    cmp_hit = '0;
    for (int i = 0; i < 3; i++) begin
      cmp_hit[i] = CC_TIMER_TICK && (CC_TIMER_COUNT == CC_COMPARE_VALUES[TIMER_W*i +: TIMER_W]); // R4
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = bus_req;
    // software writes to byte lanes 0 and 1 first, hardware sets after so set wins
    if (bus_req) begin
      if (wr_hit(flic_pkg::IDX_ENABLE_PRIMARY, WB_ADR_I, WB_WE_I, WB_SEL_I)) s_d.en_a = WB_DAT_I[7:0];
      if (wr_hit(flic_pkg::IDX_ENABLE_TIMER, WB_ADR_I, WB_WE_I, WB_SEL_I)) s_d.en_b = WB_DAT_I[7:0];
      if (wr_hit(flic_pkg::IDX_PRIO_LOW_A, WB_ADR_I, WB_WE_I, WB_SEL_I)) s_d.pl_a = {1'b0, WB_DAT_I[6:0]};
      if (wr_hit(flic_pkg::IDX_PRIO_HIGH_A, WB_ADR_I, WB_WE_I, WB_SEL_I)) s_d.ph_a = {1'b0, WB_DAT_I[6:0]};
      if (wr_hit(flic_pkg::IDX_PRIO_LOW_B, WB_ADR_I, WB_WE_I, WB_SEL_I)) s_d.pl_b = WB_DAT_I[7:0];
      if (wr_hit(flic_pkg::IDX_PRIO_HIGH_B, WB_ADR_I, WB_WE_I, WB_SEL_I)) s_d.ph_b = WB_DAT_I[7:0];
      if (wr_hit(flic_pkg::IDX_FLAGS_A, WB_ADR_I, WB_WE_I, WB_SEL_I)) begin
        // adc flag: clear only
        s_d.fl_a[6:0] = WB_DAT_I[6:0]; // R10
        s_d.fl_a[flic_pkg::FA_ADC] = s_q.fl_a[flic_pkg::FA_ADC] & WB_DAT_I[7]; // R9
      end
      if (wr_hit(flic_pkg::IDX_FLAGS_B, WB_ADR_I, WB_WE_I, WB_SEL_I)) begin
        s_d.fl_b = WB_DAT_I[7:0]; // R6 R10
      end
      if (wr_hit(flic_pkg::IDX_FLAGS_B, WB_ADR_I, WB_WE_I, {3'b000, WB_SEL_I[1]})) begin
        s_d.fovf = WB_DAT_I[8]; // R6 R10
      end
      // read mux, unmapped reads zero
      s_d.rdat = '0;
      unique case (WB_ADR_I[ADDR_W-1:flic_pkg::ADDR_LSB])
        flic_pkg::IDX_ENABLE_PRIMARY: s_d.rdat[7:0] = s_q.en_a;
        flic_pkg::IDX_ENABLE_TIMER: s_d.rdat[7:0] = s_q.en_b;
        flic_pkg::IDX_PRIO_LOW_A: s_d.rdat[7:0] = s_q.pl_a;
        flic_pkg::IDX_PRIO_HIGH_A: s_d.rdat[7:0] = s_q.ph_a;
        flic_pkg::IDX_PRIO_LOW_B: s_d.rdat[7:0] = s_q.pl_b;
        flic_pkg::IDX_PRIO_HIGH_B: s_d.rdat[7:0] = s_q.ph_b;
        flic_pkg::IDX_FLAGS_A: s_d.rdat[7:0] = s_q.fl_a;
        flic_pkg::IDX_FLAGS_B: s_d.rdat[8:0] = {s_q.fovf, s_q.fl_b};
        flic_pkg::IDX_SERVICE: s_d.rdat[3:0] = s_q.ins;
        flic_pkg::IDX_VECTOR: s_d.rdat[7:0] = s_q.vec;
        default: s_d.rdat = '0;
      endcase
    end
    // hardware sets
    s_d.fl_a[0] = s_d.fl_a[0] | EXT_REQUEST_PIN_A;
    s_d.fl_a[1] = s_d.fl_a[1] | TIMER0_OVF;
    s_d.fl_a[2] = s_d.fl_a[2] | EXT_REQUEST_PIN_B;
    s_d.fl_a[3] = s_d.fl_a[3] | TIMER1_OVF;
    s_d.fl_a[flic_pkg::FA_UART_RX] = s_d.fl_a[flic_pkg::FA_UART_RX] | UART_RX_DONE;
    s_d.fl_a[flic_pkg::FA_UART_TX] = s_d.fl_a[flic_pkg::FA_UART_TX] | UART_TX_DONE;
    s_d.fl_a[flic_pkg::FA_I2C] = s_d.fl_a[flic_pkg::FA_I2C] | I2C_STATUS_LOAD; // R8
    s_d.fl_a[flic_pkg::FA_ADC] = s_d.fl_a[flic_pkg::FA_ADC] | ADC_RESULT_READY; // R7
    s_d.fl_b[3:0] = s_d.fl_b[3:0] | CAPTURE_INPUT_SIGNAL; // R4
    s_d.fl_b[6:4] = s_d.fl_b[6:4] | cmp_hit[2:0]; // R4
    s_d.fl_b[7] = s_d.fl_b[7] | (CC_TIMER_TICK && (CC_TIMER_COUNT[7:0] == 8'hFF)); // R5
    s_d.fovf = s_d.fovf | (CC_TIMER_TICK && (&CC_TIMER_COUNT)); // R5
    // service stack: return pops highest, accept pushes winner level
    if (CPU_RETURN || (bus_req && wr_hit(flic_pkg::IDX_RETURN, WB_ADR_I, WB_WE_I, WB_SEL_I))) begin
      s_d.ins[svc_top] = 1'b0; // R16
    end
    if (CPU_ACCEPT && fwd) begin
      s_d.ins[win_lvl] = 1'b1; // R16
    end
    if (fwd) begin
      s_d.vec = flic_pkg::VEC_BASE + {win_src, 3'b000}; // R21
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_global_gate;
    @(posedge SYS_CLK) disable iff (!RST_B) !s_q.en_a[flic_pkg::GLOBAL_EN_BIT] |-> !CPU_IRQ;
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("irq with global enable clear"); // R12

  property p_no_equal_preempt;
    @(posedge SYS_CLK) disable iff (!RST_B) CPU_IRQ && svc_any |-> win_lvl > svc_top;
  endproperty
  a_no_equal_preempt: assert property (p_no_equal_preempt) else $error("preempt by equal level"); // R14 R15

  property p_enable_needed;
    @(posedge SYS_CLK) disable iff (!RST_B) CPU_IRQ |-> en[win_src] && req[win_src];
  endproperty
  a_enable_needed: assert property (p_enable_needed) else $error("disabled source forwarded"); // R11

  property p_push;
    @(posedge SYS_CLK) disable iff (!RST_B) CPU_ACCEPT && CPU_IRQ |=> s_q.ins[$past(win_lvl)];
  endproperty
  a_push: assert property (p_push) else $error("service level not recorded"); // R16

  property p_vector;
    @(posedge SYS_CLK) disable iff (!RST_B) CPU_IRQ |=> CPU_VECTOR == 8'(3 + 8 * $past(win_src));
  endproperty
  a_vector: assert property (p_vector) else $error("vector wrong"); // R21

  property p_capture_sets;
    @(posedge SYS_CLK) disable iff (!RST_B) CAPTURE_INPUT_SIGNAL[0] |=> s_q.fl_b[0];
  endproperty
  a_capture_sets: assert property (p_capture_sets) else $error("capture flag not set"); // R4

  property p_adc_no_sw_set;
    @(posedge SYS_CLK) disable iff (!RST_B) !s_q.fl_a[flic_pkg::FA_ADC] && !ADC_RESULT_READY |=> !s_q.fl_a[flic_pkg::FA_ADC];
  endproperty
  a_adc_no_sw_set: assert property (p_adc_no_sw_set) else $error("adc flag set by software"); // R9

  property p_timer_flag_sticky;
    @(posedge SYS_CLK) disable iff (!RST_B) s_q.fovf && !bus_req |=> s_q.fovf;
  endproperty
  a_timer_flag_sticky: assert property (p_timer_flag_sticky) else $error("overflow flag lost"); // R6

  property p_uart_or;
    @(posedge SYS_CLK) disable iff (!RST_B) s_q.fl_a[flic_pkg::FA_UART_TX] |-> req[flic_pkg::S_UART];
  endproperty
  a_uart_or: assert property (p_uart_or) else $error("uart request missing"); // R2

  property p_ack_one;
    @(posedge SYS_CLK) disable iff (!RST_B) WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  c_irq: cover property (@(posedge SYS_CLK) disable iff (!RST_B) CPU_IRQ && CPU_ACCEPT);
  c_nest: cover property (@(posedge SYS_CLK) disable iff (!RST_B) CPU_IRQ && svc_any);
  c_ovf: cover property (@(posedge SYS_CLK) disable iff (!RST_B) req[flic_pkg::S_OVF]);
endmodule

// ---- testbench/flic_cpu_model.sv ----
`timescale 1ns/1ps
// --------
// cpu core stand-in: takes one request per arm, after lat cycles
// --------
module flic_cpu_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cpu_irq, // request level from controller
  input wire logic arm, // bench allows one acceptance
  input wire logic [2:0] lat, // request cycles before taking
  output logic cpu_accept, // one-cycle take pulse
  output logic done // acceptance made for this arm
);
  logic [2:0] cnt; // request cycles seen so far
  // take only a request that has stood lat cycles, once per arm
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      cpu_accept <= 1'b0;
      done <= 1'b0;
    end else begin
      cpu_accept <= 1'b0;
      if (!arm) begin
        done <= 1'b0;
        cnt <= '0;
      end else if (!done && cpu_irq) begin
        if (cnt == lat) begin
          cpu_accept <= 1'b1;
          done <= 1'b1;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end
endmodule

// ---- testbench/flic_top_tb.sv ----
`timescale 1ns/1ps
module flic_top_tb;
  // --------
  // pins and bookkeeping
  // --------
  logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, ret = 1'b0, arm = 1'b0;
  logic [9:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [11:0] ev = '0; // event pins, ext a at top
  logic [15:0] cnt = '0;
  logic [47:0] cmpv = '0;
  logic [2:0] lat = '0;
  logic [31:0] rdat;
  logic ack, acc, irq, done;
  logic [7:0] vec;
  logic [31:0] expq[$]; // expected read data, oldest first
  logic [16:0] fl; // flags b above flags a
  logic [15:0] c;
  logic [7:0] r;
  int n_mismatch = 0;
  int checks_done = 0;
  int ord[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14}; // order within a level
  localparam logic [7:0] FA = flic_pkg::IDX_FLAGS_A;
  localparam logic [7:0] FB = flic_pkg::IDX_FLAGS_B;
  localparam logic [7:0] SV = flic_pkg::IDX_SERVICE;
  localparam logic [7:0] EA = flic_pkg::IDX_ENABLE_PRIMARY;
  localparam logic [7:0] EB = flic_pkg::IDX_ENABLE_TIMER;
  logic [7:0] ridx[6] = '{EA, EB, flic_pkg::IDX_PRIO_LOW_A, flic_pkg::IDX_PRIO_HIGH_A,
    flic_pkg::IDX_PRIO_LOW_B, flic_pkg::IDX_PRIO_HIGH_B};
  logic [7:0] rmsk[6] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF}; // top bit of first-group prio reads 0
  always #20 clk = ~clk;
  // --------
  // design and cpu stand-in
  // --------
  flic_top dut (.SYS_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .EXT_REQUEST_PIN_A(ev[11]), .EXT_REQUEST_PIN_B(ev[10]), .TIMER0_OVF(ev[9]), .TIMER1_OVF(ev[8]),
    .UART_RX_DONE(ev[7]), .UART_TX_DONE(ev[6]), .I2C_STATUS_LOAD(ev[5]), .ADC_RESULT_READY(ev[4]),
    .CAPTURE_INPUT_SIGNAL(ev[3:0]), .CC_TIMER_COUNT(cnt), .CC_COMPARE_VALUES(cmpv),
    .CC_TIMER_TICK(tick), .CPU_ACCEPT(acc), .CPU_RETURN(ret), .CPU_IRQ(irq), .CPU_VECTOR(vec));
  flic_cpu_model cpu (.clk(clk), .rst_b(rst_b), .cpu_irq(irq), .arm(arm), .lat(lat),
    .cpu_accept(acc), .done(done));
  // --------
  // compares and bus tasks
  // --------
  task automatic bad(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_mismatch++;
    $display("BAD %s expected %h seen %h", nm, e, g);
  endtask
  task automatic chk_rd(input logic [31:0] e);
    checks_done++;
    if (rdat !== e) bad($sformatf("read at %h", adr), e, rdat);
  endtask
  // irq level, and vector when a request stands
  task automatic chk_cpu(input logic ei, input logic [7:0] v);
    repeat (2) @(negedge clk);
    checks_done++;
    if (irq !== ei) bad("irq", {31'h0, ei}, {31'h0, irq});
    if (ei && vec !== v) bad("vector", {24'h0, v}, {24'h0, vec});
  endtask
  // classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do @(negedge clk); while (ack !== 1'b1);
    @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    wb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    expq.push_back(e);
    wb(1'b0, idx, 32'h0000_0000);
  endtask
  // read data checked when ack shows
  always @(negedge clk) if (ack === 1'b1 && we === 1'b0) chk_rd(expq.pop_front());
  task automatic tk(input logic [15:0] v);
    @(posedge clk);
    cnt <= v;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask
  task automatic take;
    @(posedge clk);
    lat <= 3'($urandom % 8);
    arm <= 1'b1;
    do @(negedge clk); while (done !== 1'b1);
    @(posedge clk);
    arm <= 1'b0;
  endtask
  task automatic pop_ret;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask
  // flag bits of a source, flags b above flags a
  function automatic logic [16:0] fmask(input int s);
    if (s < 4) return 17'h0_0001 << s;
    if (s == 4) return 17'h0_0030;
    if (s == 5) return 17'h0_0040;
    if (s < 10) return 17'h0_0001 << (s + 2);
    if (s == 10) return 17'h0_0080;
    if (s < 14) return 17'h0_0001 << (s + 1);
    return 17'h1_8000;
  endfunction
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // --------
  // watchdog and main sequence
  // --------
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    void'($urandom(14));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, readback, unmapped place
    for (int i = 0; i < 6; i++) rd(ridx[i], 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      r = 8'($urandom);
      wr(ridx[i], {24'h0, r});
      rd(ridx[i], {24'h0, r & rmsk[i]});
    end
    rd(8'h10, 32'h0000_0000);
    // software set and clear of flags
    wr(EA, 32'h0000_0000);
    wr(EB, 32'h0000_0000);
    wr(FA, 32'h0000_00FF);
    rd(FA, 32'h0000_007F);
    wr(FB, 32'h0000_01FF);
    rd(FB, 32'h0000_01FF);
    wr(FA, 32'h0000_0000);
    wr(FB, 32'h0000_0000);
    rd(FB, 32'h0000_0000);
    // hardware events
    @(posedge clk);
    ev <= 12'hFFF;
    @(posedge clk);
    ev <= 12'h000;
    for (int ch = 0; ch < 3; ch++) begin
      c = {8'($urandom), 8'($urandom % 255)};
      cmpv[16*ch +: 16] <= c;
      tk(c);
    end
    rd(FB, 32'h0000_007F);
    tk(16'h12FF);
    rd(FB, 32'h0000_00FF);
    tk(16'hFFFF);
    rd(FA, 32'h0000_00FF);
    repeat (20) @(posedge clk);
    rd(FB, 32'h0000_01FF);
    rd(FA, 32'h0000_00FF);
    // masks, then fixed order and vectors
    for (int i = 2; i < 6; i++) wr(ridx[i], 32'h0000_0000);
    wr(EA, 32'h0000_0080);
    chk_cpu(1'b0, 8'h00);
    wr(EA, 32'h0000_007F);
    wr(EB, 32'h0000_00FF);
    chk_cpu(1'b0, 8'h00);
    wr(EA, 32'h0000_00FF);
    fl = 17'h1_FFFF;
    for (int k = 0; k < 15; k++) begin
      chk_cpu(1'b1, 8'(3 + 8 * ord[k]));
      fl = fl & ~fmask(ord[k]);
      wr(FA, {24'h0, fl[7:0]});
      wr(FB, {23'h0, fl[16:8]});
    end
    chk_cpu(1'b0, 8'h00);
    // levels: ext0 0, timer0 2, ext1 3, timer1 1
    wr(flic_pkg::IDX_PRIO_LOW_A, 32'h0000_000C);
    wr(flic_pkg::IDX_PRIO_HIGH_A, 32'h0000_0006);
    wr(EB, 32'h0000_0000);
    wr(EA, 32'h0000_008F);
    wr(FA, 32'h0000_0001);
    chk_cpu(1'b1, 8'h03);
    take;
    rd(SV, 32'h0000_0001);
    chk_cpu(1'b0, 8'h00);
    wr(FA, 32'h0000_000B);
    chk_cpu(1'b1, 8'h0B);
    take;
    rd(SV, 32'h0000_0005);
    chk_cpu(1'b0, 8'h00);
    wr(FA, 32'h0000_000D);
    chk_cpu(1'b1, 8'h13);
    take;
    rd(SV, 32'h0000_000D);
    wr(FA, 32'h0000_0009);
    pop_ret;
    rd(SV, 32'h0000_0005);
    chk_cpu(1'b0, 8'h00);
    pop_ret;
    chk_cpu(1'b1, 8'h1B);
    take;
    rd(SV, 32'h0000_0003);
    wr(flic_pkg::IDX_RETURN, 32'h0000_0000);
    rd(SV, 32'h0000_0001);
    chk_cpu(1'b1, 8'h1B);
    wr(FA, 32'h0000_0001);
    chk_cpu(1'b0, 8'h00);
    pop_ret;
    chk_cpu(1'b1, 8'h03);
    rd(SV, 32'h0000_0000);
    // adc priority sits in the first group, level 2 beats pending ext0
    wr(flic_pkg::IDX_PRIO_HIGH_A, 32'h0000_0040);
    wr(EA, 32'h0000_00C1);
    @(posedge clk);
    ev <= 12'h010;
    @(posedge clk);
    ev <= 12'h000;
    chk_cpu(1'b1, 8'h53);
    take;
    rd(SV, 32'h0000_0004);
    finish_test;
  end
endmodule
